// File: design/irq_bank_pkg.sv
// Types shared by the peripheral interrupt enable and flag bank
package irq_bank_pkg;

  // Register selected by a bus address
  typedef enum logic [2:0] {
    SEL_SCAN_EN     = 3'b000,
    SEL_MEAS_EN     = 3'b001,
    SEL_CORE_FLAGS  = 3'b010,
    SEL_CLOCK_FLAGS = 3'b011,
    SEL_NONE        = 3'b100
  } reg_sel_t;

  // Register byte
  typedef logic [7:0] reg_byte_t;

endpackage

// File: design/irq_bank_regs.svh
// Register offsets, bit positions, masks and reset values of the bank
`ifndef IRQ_BANK_REGS_SVH
`define IRQ_BANK_REGS_SVH

// ==========================================
// Register offsets
`define OFS_SCAN_EN     2'h0
`define OFS_MEAS_EN     2'h1
`define OFS_CORE_FLAGS  2'h2
`define OFS_CLOCK_FLAGS 2'h3

// ==========================================
// First enable register bits
`define BIT_SCANNER_EN  7
`define BIT_CHECKSUM_EN 6
`define BIT_NVM_EN      5
`define BIT_OSC_ACC_EN  4
`define BIT_WG3_EN      2
`define BIT_WG2_EN      1
`define BIT_WG1_EN      0

// ==========================================
// Second enable register bits
`define BIT_M2_PW_EN    5
`define BIT_M2_PER_EN   4
`define BIT_M2_OVF_EN   3
`define BIT_M1_PW_EN    2
`define BIT_M1_PER_EN   1
`define BIT_M1_OVF_EN   0

// ==========================================
// Flag register bits
`define BIT_TMR0_FLAG   5
`define BIT_PINCHG_FLAG 4
`define BIT_EXTPIN_FLAG 0
`define BIT_OSCFAIL_FLG 7
`define BIT_CLKSW_FLAG  6
`define BIT_ADCTHR_FLAG 1
`define BIT_ADCDONE_FLG 0

// ==========================================
// Stored-bit masks and reset values
`define MASK_SCAN_EN    8'hF7
`define MASK_MEAS_EN    8'h3F
`define MASK_CORE_WR    8'h21
`define MASK_CLOCK_WR   8'hC3
`define RST_BANK        8'h00

`endif

// File: design/peripheral_irq_enable_flag_bank.sv
// Peripheral interrupt enable and flag register bank
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "irq_bank_regs.svh"

module peripheral_irq_enable_flag_bank #(
  parameter int PORT_FLAG_W = 40
) (
  input  wire logic                   sys_clk_i,
  input  wire logic                   srst_i,
  // Register port
  input  wire logic [1:0]             reg_addr_i,
  input  wire logic [7:0]             reg_wdata_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  output logic      [7:0]             reg_rdata_o,
  // Hardware event pulses
  input  wire logic                   tmr0_ovf_i,
  input  wire logic                   ext_pin_evt_i,
  input  wire logic                   osc_fail_i,
  input  wire logic                   clk_switch_done_i,
  input  wire logic                   adc_threshold_i,
  input  wire logic                   adc_done_i,
  // Lower-level port change flags
  input  wire logic [PORT_FLAG_W-1:0] port_change_flags_i,
  // Enables of the flags held here
  input  wire logic [7:0]             core_flag_en_i,
  input  wire logic [7:0]             clock_flag_en_i,
  // Pending flags of the enables held here
  input  wire logic [7:0]             scan_group_flags_i,
  input  wire logic [7:0]             meas_group_flags_i,
  // Gates from the control register
  input  wire logic                   peripheral_irq_gate_i,
  input  wire logic                   global_irq_gate_i,
  // Enable and flag outputs
  output logic      [7:0]             scan_en_o,
  output logic      [7:0]             meas_en_o,
  output logic      [7:0]             core_flags_o,
  output logic      [7:0]             clock_flags_o,
  output logic                        irq_o
);

  // ==========================================
  // Address decode

  // Shared by the write and read paths
  function automatic irq_bank_pkg::reg_sel_t decode_sel(
    input logic [1:0] addr
  );
    irq_bank_pkg::reg_sel_t sel;
    sel = irq_bank_pkg::SEL_NONE;
    unique case (addr)
      `OFS_SCAN_EN:     sel = irq_bank_pkg::SEL_SCAN_EN;
      `OFS_MEAS_EN:     sel = irq_bank_pkg::SEL_MEAS_EN;
      `OFS_CORE_FLAGS:  sel = irq_bank_pkg::SEL_CORE_FLAGS;
      `OFS_CLOCK_FLAGS: sel = irq_bank_pkg::SEL_CLOCK_FLAGS;
    endcase
    return sel;
  endfunction

  irq_bank_pkg::reg_sel_t wr_sel;
  irq_bank_pkg::reg_sel_t rd_sel;

  // Decoded selects
  assign wr_sel = decode_sel(reg_addr_i);
  assign rd_sel = decode_sel(reg_addr_i);

  logic wr_scan_en;
  logic wr_meas_en;
  logic wr_core;
  logic wr_clock;

  // Write strobes per register
  assign wr_scan_en = reg_wr_i && (wr_sel == irq_bank_pkg::SEL_SCAN_EN);
  assign wr_meas_en = reg_wr_i && (wr_sel == irq_bank_pkg::SEL_MEAS_EN);
  assign wr_core    = reg_wr_i && (wr_sel == irq_bank_pkg::SEL_CORE_FLAGS);
  assign wr_clock   = reg_wr_i && (wr_sel == irq_bank_pkg::SEL_CLOCK_FLAGS);

  // ==========================================
  // Enable registers

  irq_bank_pkg::reg_byte_t scan_en_r;
  irq_bank_pkg::reg_byte_t meas_en_r;

  logic scanner_irq_en;
  logic checksum_irq_en;
  logic nonvolatile_task_irq_en;
  logic osc_accum_rollover_irq_en;
  logic waveform_gen3_irq_en;
  logic waveform_gen2_irq_en;
  logic waveform_gen1_irq_en;

  // Named views of the first enable register
  assign scanner_irq_en            = scan_en_r[`BIT_SCANNER_EN];
  assign checksum_irq_en           = scan_en_r[`BIT_CHECKSUM_EN];
  assign nonvolatile_task_irq_en   = scan_en_r[`BIT_NVM_EN];
  assign osc_accum_rollover_irq_en = scan_en_r[`BIT_OSC_ACC_EN];
  assign waveform_gen3_irq_en      = scan_en_r[`BIT_WG3_EN];
  assign waveform_gen2_irq_en      = scan_en_r[`BIT_WG2_EN];
  assign waveform_gen1_irq_en      = scan_en_r[`BIT_WG1_EN];

  logic meas2_pulse_width_irq_en;
  logic meas2_period_irq_en;
  logic meas2_overflow_irq_en;
  logic meas1_pulse_width_irq_en;
  logic meas1_period_irq_en;
  logic meas1_overflow_irq_en;

  // Named views of the second enable register
  assign meas2_pulse_width_irq_en = meas_en_r[`BIT_M2_PW_EN];
  assign meas2_period_irq_en      = meas_en_r[`BIT_M2_PER_EN];
  assign meas2_overflow_irq_en    = meas_en_r[`BIT_M2_OVF_EN];
  assign meas1_pulse_width_irq_en = meas_en_r[`BIT_M1_PW_EN];
  assign meas1_period_irq_en      = meas_en_r[`BIT_M1_PER_EN];
  assign meas1_overflow_irq_en    = meas_en_r[`BIT_M1_OVF_EN];

  // First enable register, bit 3 never stores
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      scan_en_r <= `RST_BANK;
    end
    else if (wr_scan_en)
    begin
      scan_en_r <= reg_wdata_i & `MASK_SCAN_EN;
    end
  end

  // Second enable register, bits 7..6 never store
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      meas_en_r <= `RST_BANK;
    end
    else if (wr_meas_en)
    begin
      meas_en_r <= reg_wdata_i & `MASK_MEAS_EN;
    end
  end

  // ==========================================
  // Hardware events

  irq_bank_pkg::reg_byte_t core_evt;
  irq_bank_pkg::reg_byte_t clock_evt;

  // Events placed at their flag positions
  always_comb
  begin
    core_evt = `RST_BANK;
    core_evt[`BIT_TMR0_FLAG]   = tmr0_ovf_i;
    core_evt[`BIT_EXTPIN_FLAG] = ext_pin_evt_i;
  end

  // Events of the clock and converter flags
  always_comb
  begin
    clock_evt = `RST_BANK;
    clock_evt[`BIT_OSCFAIL_FLG] = osc_fail_i;
    clock_evt[`BIT_CLKSW_FLAG]  = clk_switch_done_i;
    clock_evt[`BIT_ADCTHR_FLAG] = adc_threshold_i;
    clock_evt[`BIT_ADCDONE_FLG] = adc_done_i;
  end

  // ==========================================
  // Sticky flags

  irq_bank_pkg::reg_byte_t core_flags_r;
  irq_bank_pkg::reg_byte_t core_flags_nxt;
  irq_bank_pkg::reg_byte_t clock_flags_r;
  irq_bank_pkg::reg_byte_t clock_flags_nxt;

  // Writable masks as typed constants, so single bits can be picked
  localparam irq_bank_pkg::reg_byte_t CORE_WR_MASK  = `MASK_CORE_WR;
  localparam irq_bank_pkg::reg_byte_t CLOCK_WR_MASK = `MASK_CLOCK_WR;

  // Per bit: a write stores, an event sets; set beats clear
  for (genvar i = 0; i < 8; i++)
  begin : g_flag
    always_comb
    begin
      core_flags_nxt[i] = core_flags_r[i];
      if (wr_core)
      begin
        core_flags_nxt[i] = reg_wdata_i[i];
      end
      core_flags_nxt[i] = (core_flags_nxt[i] | core_evt[i])
                          & CORE_WR_MASK[i];
    end

    always_comb
    begin
      clock_flags_nxt[i] = clock_flags_r[i];
      if (wr_clock)
      begin
        clock_flags_nxt[i] = reg_wdata_i[i];
      end
      clock_flags_nxt[i] = (clock_flags_nxt[i] | clock_evt[i])
                           & CLOCK_WR_MASK[i];
    end
  end

  // Timer zero and external pin flags
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      core_flags_r <= `RST_BANK;
    end
    else
    begin
      core_flags_r <= core_flags_nxt;
    end
  end

  // Oscillator, clock switch and converter flags
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      clock_flags_r <= `RST_BANK;
    end
    else
    begin
      clock_flags_r <= clock_flags_nxt;
    end
  end

  // ==========================================
  // Named views of the stored flags

  logic timer_zero_overflow_flag;
  logic external_pin_irq_flag;
  logic osc_failsafe_flag;
  logic clock_switch_done_flag;
  logic adc_threshold_flag;
  logic adc_complete_flag;

  // Stored bits by event; the summary bit is live and kept apart
  assign timer_zero_overflow_flag = core_flags_r[`BIT_TMR0_FLAG];
  assign external_pin_irq_flag    = core_flags_r[`BIT_EXTPIN_FLAG];
  assign osc_failsafe_flag        = clock_flags_r[`BIT_OSCFAIL_FLG];
  assign clock_switch_done_flag   = clock_flags_r[`BIT_CLKSW_FLAG];
  assign adc_threshold_flag       = clock_flags_r[`BIT_ADCTHR_FLAG];
  assign adc_complete_flag        = clock_flags_r[`BIT_ADCDONE_FLG];

  // ==========================================
  // Pin change summary

  logic pin_change_summary_flag;

  // Live OR; clears only when every port flag is cleared
  assign pin_change_summary_flag = |port_change_flags_i;

  irq_bank_pkg::reg_byte_t core_view;

  // Stored flags plus the read-only summary bit
  always_comb
  begin
    core_view = core_flags_r;
    core_view[`BIT_PINCHG_FLAG] = pin_change_summary_flag;
  end

  // ==========================================
  // Read path

  irq_bank_pkg::reg_byte_t rdata_nxt;
  irq_bank_pkg::reg_byte_t rdata_r;

  // Unmapped or unused bits read zero
  always_comb
  begin
    rdata_nxt = `RST_BANK;
    unique case (rd_sel)
      irq_bank_pkg::SEL_SCAN_EN:     rdata_nxt = scan_en_r;
      irq_bank_pkg::SEL_MEAS_EN:     rdata_nxt = meas_en_r;
      irq_bank_pkg::SEL_CORE_FLAGS:  rdata_nxt = core_view;
      irq_bank_pkg::SEL_CLOCK_FLAGS: rdata_nxt = clock_flags_r;
      irq_bank_pkg::SEL_NONE:        rdata_nxt = `RST_BANK;
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      rdata_r <= `RST_BANK;
    end
    else if (reg_rd_i)
    begin
      rdata_r <= rdata_nxt;
    end
    else
    begin
      rdata_r <= `RST_BANK;
    end
  end

  assign reg_rdata_o = rdata_r;

  // ==========================================
  // Request combine

  irq_bank_pkg::reg_byte_t pend_core;
  irq_bank_pkg::reg_byte_t pend_clock;
  irq_bank_pkg::reg_byte_t pend_scan;
  irq_bank_pkg::reg_byte_t pend_meas;

  // Flag and enable pairs from the named bits; holes stay zero
  // Enables only gate the request, never mask the flags themselves
  assign pend_core  = core_flag_en_i
                    & {2'b00, timer_zero_overflow_flag, pin_change_summary_flag,
                       3'b000, external_pin_irq_flag};
  assign pend_clock = clock_flag_en_i
                    & {osc_failsafe_flag, clock_switch_done_flag, 4'h0,
                       adc_threshold_flag, adc_complete_flag};
  assign pend_scan  = scan_group_flags_i
                    & {scanner_irq_en, checksum_irq_en, nonvolatile_task_irq_en,
                       osc_accum_rollover_irq_en, 1'b0, waveform_gen3_irq_en,
                       waveform_gen2_irq_en, waveform_gen1_irq_en};
  assign pend_meas  = meas_group_flags_i
                    & {2'b00, meas2_pulse_width_irq_en, meas2_period_irq_en,
                       meas2_overflow_irq_en, meas1_pulse_width_irq_en,
                       meas1_period_irq_en, meas1_overflow_irq_en};

  logic any_pend;
  logic irq_r;

  // Any enabled pending source
  assign any_pend = (|pend_core) | (|pend_clock)
                  | (|pend_scan) | (|pend_meas);

  // Registered request; one cycle of latency keeps the core glitch-free
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      irq_r <= 1'b0;
    end
    else
    begin
      irq_r <= any_pend
             & peripheral_irq_gate_i
             & global_irq_gate_i;
    end
  end

  assign irq_o = irq_r;

  // ==========================================
  // Register outputs
  assign scan_en_o     = scan_en_r;
  assign meas_en_o     = meas_en_r;
  assign core_flags_o  = core_view;
  assign clock_flags_o = clock_flags_r;

endmodule

`default_nettype wire

// File: verification/event_source_model.sv
// Model of the peripheral event sources around the bank
`timescale 1ns/1ps
`default_nettype none

module event_source_model (
  input  wire logic       sys_clk_i,
  input  wire logic       srst_i,
  input  wire logic [5:0] fire_i,
  output logic      [5:0] evt_o
);
  // ==========================================
  // Event strobes, launched on a clock edge like a real peripheral
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      evt_o <= 6'h00;
    else
      evt_o <= fire_i;
  end
endmodule
`default_nettype wire

// File: verification/irq_bank_chk.sv
// Port checker of the peripheral interrupt enable and flag bank
`timescale 1ns/1ps
`default_nettype none

module irq_bank_chk #(
  parameter int PORT_FLAG_W = 40
) (
  input wire logic                   sys_clk_i,
  input wire logic                   srst_i,
  input wire logic [1:0]             reg_addr_i,
  input wire logic [7:0]             reg_wdata_i,
  input wire logic                   reg_wr_i,
  input wire logic                   reg_rd_i,
  input wire logic [7:0]             reg_rdata_o,
  input wire logic                   tmr0_ovf_i,
  input wire logic                   ext_pin_evt_i,
  input wire logic                   osc_fail_i,
  input wire logic                   clk_switch_done_i,
  input wire logic                   adc_threshold_i,
  input wire logic                   adc_done_i,
  input wire logic [PORT_FLAG_W-1:0] port_change_flags_i,
  input wire logic [7:0]             core_flag_en_i,
  input wire logic [7:0]             clock_flag_en_i,
  input wire logic [7:0]             scan_group_flags_i,
  input wire logic [7:0]             meas_group_flags_i,
  input wire logic                   peripheral_irq_gate_i,
  input wire logic                   global_irq_gate_i,
  input wire logic [7:0]             scan_en_o,
  input wire logic [7:0]             meas_en_o,
  input wire logic [7:0]             core_flags_o,
  input wire logic [7:0]             clock_flags_o,
  input wire logic                   irq_o
);
  // ==========================================
  // Expected request and read-back value
  logic       want;
  logic [7:0] rd_val;
  assign want = peripheral_irq_gate_i && global_irq_gate_i &&
    |((core_flags_o & core_flag_en_i) | (clock_flags_o & clock_flag_en_i) |
      (scan_en_o & scan_group_flags_i) | (meas_en_o & meas_group_flags_i));
  // Core flag bit 4 is live, so the read must catch it at the strobe edge
  assign rd_val = reg_addr_i == 2'h0 ? scan_en_o : reg_addr_i == 2'h1 ? meas_en_o :
    reg_addr_i == 2'h2 ? core_flags_o : clock_flags_o;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  // Software write to the clock and ADC flags
  sequence clk_flag_wr;
    reg_wr_i && reg_addr_i == 2'h3;
  endsequence

  // ==========================================
  // Assertions
  scan_write_a: assert property (
    reg_wr_i && reg_addr_i == 2'h0 |=> scan_en_o == ($past(reg_wdata_i) & 8'hF7))
    else $error("first enable write wrong");
  meas_write_a: assert property (
    reg_wr_i && reg_addr_i == 2'h1 |=> meas_en_o == ($past(reg_wdata_i) & 8'h3F))
    else $error("second enable write wrong");
  unused_zero_a: assert property (
    ((scan_en_o & 8'h08) | (meas_en_o & 8'hC0) | (core_flags_o & 8'hCE) |
     (clock_flags_o & 8'h3C)) == 8'h00) else $error("unused bit set");
  summary_or_a: assert property (core_flags_o[4] == |port_change_flags_i)
    else $error("summary flag wrong");
  event_set_a: assert property (
    1'b1 |=> (core_flags_o[5] || !$past(tmr0_ovf_i)) && (core_flags_o[0] || !$past(ext_pin_evt_i))
      && (clock_flags_o[7] || !$past(osc_fail_i)) && (clock_flags_o[6] || !$past(clk_switch_done_i))
      && (clock_flags_o[1] || !$past(adc_threshold_i)) && (clock_flags_o[0] || !$past(adc_done_i)))
    else $error("event did not set flag");
  flag_hold_a: assert property (
    !(reg_wr_i && reg_addr_i[1]) |=> (clock_flags_o & $past(clock_flags_o)) == $past(clock_flags_o)
      && (core_flags_o & $past(core_flags_o) & 8'h21) == ($past(core_flags_o) & 8'h21))
    else $error("flag dropped without write");
  flag_clear_a: assert property (
    clk_flag_wr ##0 (!adc_done_i && !reg_wdata_i[0]) |=> !clock_flags_o[0])
    else $error("flag not cleared");
  irq_req_a: assert property (!$past(srst_i) |-> irq_o == $past(want))
    else $error("request wrong");
  gate_off_a: assert property (!peripheral_irq_gate_i |=> !irq_o)
    else $error("request through closed gate");
  read_back_a: assert property (reg_rd_i |=> reg_rdata_o == $past(rd_val))
    else $error("read data wrong");
  reset_zero_a: assert property (disable iff (1'b0)
    $past(srst_i) |-> (scan_en_o | meas_en_o | clock_flags_o | (core_flags_o & 8'hEF)) == 8'h00
      && !irq_o) else $error("reset value wrong");
  rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data outside read cycle");
  set_wins_a: assert property (clk_flag_wr ##0 adc_done_i |=> clock_flags_o[0])
    else $error("clear beat a same-cycle event");
endmodule

bind peripheral_irq_enable_flag_bank irq_bank_chk #(.PORT_FLAG_W(PORT_FLAG_W)) chk (.*);
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench of the peripheral interrupt enable and flag bank
`timescale 1ns/1ps
`default_nettype none

module testbench;
  // ==========================================
  // Signals
  logic        sys_clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, pgate = 1'b0, ggate = 1'b0;
  logic [1:0]  addr = 2'h0;
  logic [5:0]  fire = 6'h00, evt;
  logic [7:0]  wdata = 8'h00, core_en = 8'h00, clk_en = 8'h00, scan_grp = 8'h00;
  logic [7:0]  meas_grp = 8'h00, rdata, scan_en, meas_en, core_f, clk_f;
  logic [39:0] pflags = 40'h00_0000_0000;
  logic        irq;
  int          n_errors = 0, tests_run = 0;

  always #50 sys_clk = ~sys_clk;

  peripheral_irq_enable_flag_bank #(.PORT_FLAG_W(40)) uut (
    .sys_clk_i(sys_clk), .srst_i(srst), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .tmr0_ovf_i(evt[5]),
    .ext_pin_evt_i(evt[4]), .osc_fail_i(evt[3]), .clk_switch_done_i(evt[2]),
    .adc_threshold_i(evt[1]), .adc_done_i(evt[0]), .port_change_flags_i(pflags),
    .core_flag_en_i(core_en), .clock_flag_en_i(clk_en), .scan_group_flags_i(scan_grp),
    .meas_group_flags_i(meas_grp), .peripheral_irq_gate_i(pgate), .global_irq_gate_i(ggate),
    .scan_en_o(scan_en), .meas_en_o(meas_en), .core_flags_o(core_f), .clock_flags_o(clk_f),
    .irq_o(irq));
  event_source_model src (.sys_clk_i(sys_clk), .srst_i(srst), .fire_i(fire), .evt_o(evt));

  // ==========================================
  // Tasks
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // One-cycle strobes; the edge after lowering is never reused for a new strobe
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [1:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    chk("read data", exp, rdata);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Event strobes take two edges to reach the flags
  task automatic pulse(input logic [5:0] m);
    @(posedge sys_clk);
    fire <= m;
    @(posedge sys_clk);
    fire <= 6'h00;
    tick(1);
  endtask
  task automatic test_done;
    $display("%0d checks, %0d mismatches", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ==========================================
  // Watchdog, far beyond the 178 cycles the run needs
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    n_errors++;
    test_done;
  end

  // ==========================================
  // Tests
  initial
  begin
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    for (int a = 0; a < 4; a++) rd_reg(a[1:0], 8'h00);
    $display("test reset done");
    wr_reg(2'h0, 8'hFF);
    rd_reg(2'h0, 8'hF7);
    wr_reg(2'h1, 8'hFF);
    rd_reg(2'h1, 8'h3F);
    wr_reg(2'h0, 8'h08);
    rd_reg(2'h0, 8'h00);
    wr_reg(2'h1, 8'h00);
    rd_reg(2'h1, 8'h00);
    $display("test enables done");
    @(posedge sys_clk);
    pgate <= 1'b1;
    ggate <= 1'b1;
    pulse(6'h3F);
    chk("core flags", 8'h21, core_f);
    chk("clock flags", 8'hC3, clk_f);
    chk("request", 8'h00, {7'h00, irq});
    rd_reg(2'h2, 8'h21);
    wr_reg(2'h3, 8'hC2);
    rd_reg(2'h3, 8'hC2);
    wr_reg(2'h3, 8'h00);
    rd_reg(2'h3, 8'h00);
    wr_reg(2'h2, 8'h00);
    rd_reg(2'h2, 8'h00);
    $display("test flags done");
    @(posedge sys_clk);
    pflags <= 40'h80_0000_0000;
    wr_reg(2'h2, 8'hFF);
    rd_reg(2'h2, 8'h31);
    wr_reg(2'h2, 8'h00);
    rd_reg(2'h2, 8'h10);
    @(posedge sys_clk);
    pflags <= 40'h00_0000_0000;
    rd_reg(2'h2, 8'h00);
    $display("test summary done");
    for (int i = 0; i < 8; i++)
    begin
      @(posedge sys_clk);
      scan_grp <= 8'h01 << i;
      meas_grp <= 8'h01 << i;
      wr_reg(2'h0, 8'h01 << i);
      tick(1);
      chk("scan request", {7'h00, i != 3}, {7'h00, irq});
      wr_reg(2'h0, 8'h00);
      wr_reg(2'h1, 8'h01 << i);
      tick(1);
      chk("timer request", {7'h00, i < 6}, {7'h00, irq});
      wr_reg(2'h1, 8'h00);
    end
    $display("test enable requests done");
    @(posedge sys_clk);
    clk_en <= 8'h01;
    pgate <= 1'b0;
    pulse(6'h01);
    tick(1);
    chk("gated request", 8'h00, {7'h00, irq});
    @(posedge sys_clk);
    pgate <= 1'b1;
    tick(1);
    chk("open request", 8'h01, {7'h00, irq});
    @(posedge sys_clk);
    ggate <= 1'b0;
    tick(1);
    chk("global off request", 8'h00, {7'h00, irq});
    $display("test gates done");
    wr_reg(2'h3, 8'h00);
    rd_reg(2'h3, 8'h00);
    @(posedge sys_clk);
    fire <= 6'h01;
    @(posedge sys_clk);
    fire <= 6'h00;
    addr <= 2'h3;
    wdata <= 8'h00;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
    #1;
    chk("set over clear", 8'h01, clk_f);
    $display("test set over clear done");
    wr_reg(2'h0, 8'hF7);
    @(posedge sys_clk);
    srst <= 1'b1;
    tick(2);
    chk("enable after reset", 8'h00, scan_en);
    chk("flags after reset", 8'h00, clk_f);
    @(posedge sys_clk);
    srst <= 1'b0;
    rd_reg(2'h0, 8'h00);
    $display("test second reset done");
    test_done;
  end
endmodule
`default_nettype wire
